// ===== design/dsc_pkg.sv
package dsc_pkg;

  // parallel word width of the recovered data
  localparam int WORD_W = 10;

  // wishbone register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam logic [7:0] REG_WORD = 8'h10;

  // control register fields and reset value
  localparam int CTRL_SW_EN_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;

  // status register fields
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_SLEEP_N_BIT = 1;
  localparam int STAT_OUT_EN_BIT = 2;
  localparam int STAT_DATA_OE_BIT = 3;
  localparam int STAT_CLK_OE_BIT = 4;
  localparam int STAT_EDGE_BIT = 5;

  // interrupt status and mask fields
  localparam int IRQ_W = 3;
  localparam int IRQ_LOCK_GAIN_BIT = 0;
  localparam int IRQ_LOCK_LOST_BIT = 1;
  localparam int IRQ_SLEEP_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  // cycles from a word load to the active recovered clock edge
  localparam logic [1:0] RCLK_SETUP_CYC = 2'h1;

  // consecutive tck rises with tms high that reset the test port
  localparam logic [2:0] TAP_RESET_EDGES = 3'h5;

  // classic wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } dsc_wb_req_t;

  // synchronised pin levels
  typedef struct packed {
    logic sleep_n;
    logic out_en;
    logic edge_sel;
    logic pll_lock;
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } dsc_pins_t;

  // output enables of the three pin groups, high while driven
  typedef struct packed {
    logic data;
    logic clk;
    logic lock;
  } dsc_oe_t;

  // output control state
  typedef enum logic [3:0] {
    ST_SLEEP = 4'b0001,
    ST_ACQUIRE = 4'b0010,
    ST_HOLD = 4'b0100,
    ST_DRIVE = 4'b1000
  } dsc_state_t;

endpackage

// ===== design/dsc_sync.sv
`timescale 1ns/1ps
// two flip-flop synchroniser; only the second stage may be used
module dsc_sync #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // meta stage feeds nothing but the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// ===== design/dsc_deser_ctrl.sv
// The implementer's own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module dsc_deser_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire dsc_pkg::dsc_wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sleep_n_i,
  input wire logic out_en_i,
  input wire logic recovered_clk_edge_sel_i,
  input wire logic pll_lock_i,
  input wire logic word_stb_i,
  input wire logic [dsc_pkg::WORD_W-1:0] word_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  output logic [dsc_pkg::WORD_W-1:0] parallel_data_out_o,
  output logic recovered_clk_o,
  output logic lock_n_o,
  output dsc_pkg::dsc_oe_t oe_o,
  output logic pll_run_o,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic irq_o
);

  dsc_pkg::dsc_pins_t pins_s;
  dsc_pkg::dsc_state_t st_q;
  dsc_pkg::dsc_state_t st_d;
  logic locked_q;
  logic asleep_q;
  logic [31:0] ctrl_q;
  logic [dsc_pkg::IRQ_W-1:0] irq_stat_q;
  logic [dsc_pkg::IRQ_W-1:0] irq_mask_q;
  logic [dsc_pkg::IRQ_W-1:0] irq_ev;
  logic [dsc_pkg::WORD_W-1:0] dout_q;
  logic rclk_q;
  logic esel_lat_q;
  logic [1:0] setup_cnt_q;
  logic word_ld_q;
  logic tck_prev_q;
  logic bypass_q;
  logic [2:0] tms_cnt_q;
  logic wb_hit;
  logic wb_wr;
  logic locked_now;

  // all pins come from outside the clock domain
  dsc_sync #(
    .W(8)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({sleep_n_i, out_en_i, recovered_clk_edge_sel_i, pll_lock_i,
              tck_i, tms_i, tdi_i, trst_n_i}),
    .sync_o(pins_s)
  );

  // byte-lane write of a field held in lane 0
  function automatic logic [dsc_pkg::IRQ_W-1:0] lane0_mask(input logic [3:0] sel,
                                                           input logic [31:0] dat);
    lane0_mask = sel[0] ? dat[dsc_pkg::IRQ_W-1:0] : '0;
  endfunction

  assign locked_now = pins_s.sleep_n & pins_s.pll_lock;

  // next control state from sleep, enable and lock
  always_comb begin
    st_d = dsc_pkg::ST_SLEEP;
    case (st_q)
      dsc_pkg::ST_SLEEP,
      dsc_pkg::ST_ACQUIRE,
      dsc_pkg::ST_HOLD,
      dsc_pkg::ST_DRIVE: begin
        if (!pins_s.sleep_n) begin
          st_d = dsc_pkg::ST_SLEEP;
        end else if (!pins_s.pll_lock) begin
          st_d = dsc_pkg::ST_ACQUIRE;
        end else if (!pins_s.out_en) begin
          st_d = dsc_pkg::ST_HOLD;
        end else begin
          st_d = dsc_pkg::ST_DRIVE;
        end
      end
      default: begin
        st_d = dsc_pkg::ST_SLEEP;
      end
    endcase
  end

  // state register; reset starts asleep so no pin is driven at power-up
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= dsc_pkg::ST_SLEEP;
    end else begin
      st_q <= st_d;
    end
  end

  // per-group pin enables, registered so outputs come from flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oe_o <= '0;
      pll_run_o <= 1'b0;
    end else begin
      oe_o.lock <= (st_d != dsc_pkg::ST_SLEEP);
      oe_o.clk <= (st_d == dsc_pkg::ST_DRIVE);
      // software enable only withholds data, the clock keeps its pin
      oe_o.data <= (st_d == dsc_pkg::ST_DRIVE) & ctrl_q[dsc_pkg::CTRL_SW_EN_BIT];
      pll_run_o <= pins_s.sleep_n;
    end
  end

  // lock flag and active-low lock pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      locked_q <= 1'b0;
      asleep_q <= 1'b1;
      lock_n_o <= 1'b1;
    end else begin
      locked_q <= locked_now;
      asleep_q <= ~pins_s.sleep_n;
      lock_n_o <= ~locked_now;
    end
  end

  // word load and recovered clock phase; the clock sits on the inactive
  // level at the load so the data has a full cycle of setup to the edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dout_q <= '0;
      rclk_q <= 1'b0;
      esel_lat_q <= 1'b1;
      setup_cnt_q <= 2'h0;
      word_ld_q <= 1'b0;
    end else begin
      word_ld_q <= word_stb_i & locked_q;
      if (!locked_q) begin
        rclk_q <= ~pins_s.edge_sel; // clock stops while not acquired
        setup_cnt_q <= 2'h0;
      end else if (word_stb_i) begin
        dout_q <= word_i;
        rclk_q <= ~pins_s.edge_sel;
        esel_lat_q <= pins_s.edge_sel;
        setup_cnt_q <= dsc_pkg::RCLK_SETUP_CYC;
      end else if (setup_cnt_q != 2'h0) begin
        setup_cnt_q <= setup_cnt_q - 2'h1;
        if (setup_cnt_q == 2'h1) begin
          rclk_q <= esel_lat_q; // active edge one cycle after the load
        end
      end
    end
  end

  assign parallel_data_out_o = dout_q;
  assign recovered_clk_o = rclk_q;

  // minimal test port: bypass cell, tms-high reset, trst low reset
  // tdo shifts on the falling tck as the test standard expects
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tck_prev_q <= 1'b0;
      bypass_q <= 1'b0;
      tms_cnt_q <= 3'h0;
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else begin
      tck_prev_q <= pins_s.tck;
      if (!pins_s.trst_n) begin
        bypass_q <= 1'b0;
        tms_cnt_q <= dsc_pkg::TAP_RESET_EDGES;
        tdo_oe_o <= 1'b0;
      end else if (pins_s.tck && !tck_prev_q) begin
        if (pins_s.tms) begin
          if (tms_cnt_q != dsc_pkg::TAP_RESET_EDGES) begin
            tms_cnt_q <= tms_cnt_q + 3'h1;
          end
        end else begin
          tms_cnt_q <= 3'h0;
          bypass_q <= pins_s.tdi;
        end
      end else if (!pins_s.tck && tck_prev_q) begin
        tdo_o <= bypass_q;
        tdo_oe_o <= (tms_cnt_q != dsc_pkg::TAP_RESET_EDGES);
      end
    end
  end

  // wishbone slave: ack one cycle after the request, writes land at that ack
  assign wb_hit = wb_req_i.cyc & wb_req_i.stb;
  assign wb_wr = wb_hit & wb_req_i.we & wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit & ~wb_ack_o;
      if (wb_hit && !wb_ack_o) begin
        case (wb_req_i.adr)
          dsc_pkg::REG_CTRL: wb_dat_o <= ctrl_q;
          dsc_pkg::REG_STATUS: begin
            wb_dat_o <= 32'h0000_0000;
            wb_dat_o[dsc_pkg::STAT_LOCK_BIT] <= locked_q;
            wb_dat_o[dsc_pkg::STAT_SLEEP_N_BIT] <= pins_s.sleep_n;
            wb_dat_o[dsc_pkg::STAT_OUT_EN_BIT] <= pins_s.out_en;
            wb_dat_o[dsc_pkg::STAT_DATA_OE_BIT] <= oe_o.data;
            wb_dat_o[dsc_pkg::STAT_CLK_OE_BIT] <= oe_o.clk;
            wb_dat_o[dsc_pkg::STAT_EDGE_BIT] <= pins_s.edge_sel;
          end
          dsc_pkg::REG_IRQ_STAT: wb_dat_o <= {29'h0, irq_stat_q};
          dsc_pkg::REG_IRQ_MASK: wb_dat_o <= {29'h0, irq_mask_q};
          dsc_pkg::REG_WORD: wb_dat_o <= {22'h0, dout_q};
          default: wb_dat_o <= 32'h0000_0000; // unmapped reads zero
        endcase
      end
    end
  end

  // control register, only the software enable bit is kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= dsc_pkg::CTRL_RST;
    end else if (wb_wr && wb_req_i.adr == dsc_pkg::REG_CTRL && wb_req_i.sel[0]) begin
      ctrl_q <= {31'h0, wb_req_i.dat[dsc_pkg::CTRL_SW_EN_BIT]};
    end
  end

  // events: lock gained, lock lost, sleep entered
  assign irq_ev = {pins_s.sleep_n ? 1'b0 : ~asleep_q,
                   locked_q & ~locked_now,
                   locked_now & ~locked_q};

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
      irq_mask_q <= dsc_pkg::IRQ_MASK_RST;
      irq_o <= 1'b0;
    end else begin
      if (wb_wr && wb_req_i.adr == dsc_pkg::REG_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~lane0_mask(wb_req_i.sel, wb_req_i.dat)) | irq_ev;
      end else begin
        irq_stat_q <= irq_stat_q | irq_ev;
      end
      if (wb_wr && wb_req_i.adr == dsc_pkg::REG_IRQ_MASK && wb_req_i.sel[0]) begin
        irq_mask_q <= wb_req_i.dat[dsc_pkg::IRQ_W-1:0];
      end
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  // checks on the pin groups, clock, test port and interrupt
  property p_edge_align;
    @(posedge clk_i) disable iff (rst_i)
      word_ld_q && locked_q |-> (rclk_q == ~esel_lat_q) ##1 (rclk_q == esel_lat_q);
  endproperty
  a_edge_align: assert property (p_edge_align) else $error("clock edge misaligned");

  property p_sleep_off;
    @(posedge clk_i) disable iff (rst_i)
      !pins_s.sleep_n |=> !oe_o.data && !oe_o.clk && !oe_o.lock && !pll_run_o;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("pin driven in sleep");

  property p_lock_low;
    @(posedge clk_i) disable iff (rst_i)
      $rose(locked_now) |=> !lock_n_o && oe_o.lock;
  endproperty
  a_lock_low: assert property (p_lock_low) else $error("lock pin not low");

  property p_oe_low;
    @(posedge clk_i) disable iff (rst_i)
      pins_s.sleep_n && !pins_s.out_en |=> !oe_o.data && !oe_o.clk && oe_o.lock;
  endproperty
  a_oe_low: assert property (p_oe_low) else $error("enable low not honoured");

  property p_unlocked_off;
    @(posedge clk_i) disable iff (rst_i)
      lock_n_o |-> !oe_o.data && !oe_o.clk;
  endproperty
  a_unlocked_off: assert property (p_unlocked_off) else $error("driven while unlocked");

  property p_drive;
    @(posedge clk_i) disable iff (rst_i)
      locked_now && pins_s.out_en && ctrl_q[dsc_pkg::CTRL_SW_EN_BIT] |=> oe_o.data && oe_o.clk;
  endproperty
  a_drive: assert property (p_drive) else $error("outputs not driven");

  property p_word_load;
    @(posedge clk_i) disable iff (rst_i)
      word_stb_i && locked_q |=> parallel_data_out_o == $past(word_i);
  endproperty
  a_word_load: assert property (p_word_load) else $error("word not loaded");

  property p_trst;
    @(posedge clk_i) disable iff (rst_i)
      !pins_s.trst_n |=> !tdo_oe_o && !bypass_q;
  endproperty
  a_trst: assert property (p_trst) else $error("test reset ignored");

  property p_group_oe;
    @(posedge clk_i) disable iff (rst_i)
      oe_o.data |-> oe_o.clk && oe_o.lock && !lock_n_o;
  endproperty
  a_group_oe: assert property (p_group_oe) else $error("enable groups inconsistent");

  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
      |(irq_stat_q & irq_mask_q) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  c_drive: cover property (@(posedge clk_i) disable iff (rst_i) $rose(oe_o.data));
  c_lost: cover property (@(posedge clk_i) disable iff (rst_i) $rose(lock_n_o) && oe_o.lock);
  c_sleep: cover property (@(posedge clk_i) disable iff (rst_i) $fell(pll_run_o));
  c_word: cover property (@(posedge clk_i) disable iff (rst_i) word_ld_q && oe_o.data);

endmodule

// ===== test/dsc_far_model.sv
`timescale 1ns/1ps
// far-side stand-in: locks after an acquisition delay, sends one word per request
module dsc_far_model #(
  parameter int ACQ_CYC = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic lock_req_i,
  input wire logic send_i,
  input wire logic [dsc_pkg::WORD_W-1:0] word_val_i,
  output logic pll_lock_o,
  output logic word_stb_o,
  output logic [dsc_pkg::WORD_W-1:0] word_o
);
  logic [3:0] acq_q;
  // lock is reported only after the acquisition time, so locking is never instant
  always_ff @(posedge clk_i) begin
    if (rst_i || !lock_req_i) begin
      acq_q <= 4'h0;
      pll_lock_o <= 1'b0;
    end else if (acq_q < ACQ_CYC) begin
      acq_q <= acq_q + 4'h1;
    end else begin
      pll_lock_o <= 1'b1;
    end
  end
  // word valid only with its strobe; otherwise the inverse shows, not a stale value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_stb_o <= 1'b0;
      word_o <= '0;
    end else begin
      word_stb_o <= send_i;
      word_o <= send_i ? word_val_i : ~word_o;
    end
  end
endmodule

// ===== test/tb_dsc_deser_ctrl.sv
`timescale 1ns/1ps
module tb_dsc_deser_ctrl;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  dsc_pkg::dsc_wb_req_t req = '0;
  logic sleep_n = 1'b1, out_en = 1'b1, sel = 1'b1, lock_req = 1'b0;
  logic send = 1'b0, trst_n = 1'b1, pll_lock, wstb, wb_ack, rclk, lock_n;
  logic tck = 1'b0, tms = 1'b1, tdi = 1'b1;
  logic pll_run, tdo, tdo_oe, irq;
  logic [dsc_pkg::WORD_W-1:0] wval = '0, word, pdata;
  logic [31:0] wb_dat;
  dsc_pkg::dsc_oe_t oe;
  int fails = 0, check_count = 0, ticks = 0;

  always #4 clk_i = ~clk_i;

  // the stand-in pll can only acquire while the block lets its pll run
  dsc_far_model u_far (.clk_i(clk_i), .rst_i(rst_i), .lock_req_i(lock_req & pll_run),
    .send_i(send),
    .word_val_i(wval), .pll_lock_o(pll_lock), .word_stb_o(wstb), .word_o(word));

  // tms, tdi and trst idle high as their pull-ups leave them, tck rests low
  dsc_deser_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(wb_dat),
    .wb_ack_o(wb_ack), .sleep_n_i(sleep_n), .out_en_i(out_en),
    .recovered_clk_edge_sel_i(sel), .pll_lock_i(pll_lock), .word_stb_i(wstb),
    .word_i(word), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n),
    .parallel_data_out_o(pdata), .recovered_clk_o(rclk), .lock_n_o(lock_n), .oe_o(oe),
    .pll_run_o(pll_run), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .irq_o(irq));

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk_i) begin
    ticks++;
    if (ticks == 5000) begin
      fails++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    // no limit of its own: only the bench timeout ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    q = wb_dat;
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic t_reset;
    logic [31:0] q;
    cyc(6);
    chk(lock_n, 1'b1);
    chk(oe, 3'b001);
    chk(pll_run, 1'b1);
    wb(1'b0, dsc_pkg::REG_CTRL, 32'h0, q);
    chk(q, dsc_pkg::CTRL_RST);
    // awake, enabled, rising edge chosen, not yet acquired so data and clock not driven
    wb(1'b0, dsc_pkg::REG_STATUS, 32'h0, q);
    chk(q, 32'h0000_0026);
    wb(1'b0, dsc_pkg::REG_IRQ_MASK, 32'h0, q);
    chk(q, 32'h0);
    wr(8'h20, 32'hffff_ffff);
    wb(1'b0, 8'h20, 32'h0, q);
    chk(q, 32'h0);
  endtask

  // lock gained raises the event; mask and write-one-clear steer the line
  task automatic t_irq_lock;
    wr(dsc_pkg::REG_IRQ_STAT, 32'h7);
    wr(dsc_pkg::REG_IRQ_MASK, 32'h1);
    cyc(2);
    chk(irq, 1'b0);
    lock_req <= 1'b1;
    cyc(14);
    chk(lock_n, 1'b0);
    chk(oe, 3'b111);
    chk(irq, 1'b1);
    wr(dsc_pkg::REG_IRQ_MASK, 32'h0);
    cyc(2);
    chk(irq, 1'b0);
    wr(dsc_pkg::REG_IRQ_MASK, 32'h1);
    cyc(2);
    chk(irq, 1'b1);
    wr(dsc_pkg::REG_IRQ_STAT, 32'h1);
    cyc(2);
    chk(irq, 1'b0);
  endtask

  // data changes opposite the chosen edge, the chosen edge follows a cycle later
  task automatic t_word(input logic s, input logic [9:0] w);
    logic [31:0] q;
    sel <= s;
    cyc(6);
    send <= 1'b1;
    wval <= w;
    cyc(1);
    send <= 1'b0;
    cyc(2);
    chk(pdata, w);
    chk(rclk, !s);
    cyc(1);
    chk(rclk, s);
    chk(pdata, w);
    wb(1'b0, dsc_pkg::REG_WORD, 32'h0, q);
    chk(q, w);
  endtask

  task automatic t_out_en;
    out_en <= 1'b0;
    cyc(6);
    chk(oe, 3'b001);
    chk(lock_n, 1'b0);
    out_en <= 1'b1;
    wr(dsc_pkg::REG_CTRL, 32'h0);
    cyc(6);
    chk(oe, 3'b011);
    wr(dsc_pkg::REG_CTRL, 32'h1);
  endtask

  task automatic t_sleep;
    logic [31:0] q;
    sleep_n <= 1'b0;
    cyc(6);
    chk(oe, 3'b000);
    chk(pll_run, 1'b0);
    wb(1'b0, dsc_pkg::REG_IRQ_STAT, 32'h0, q);
    chk(q[dsc_pkg::IRQ_SLEEP_BIT], 1'b1);
    sleep_n <= 1'b1;
    // the pll restarts on wake and must acquire again before data and clock pins are driven
    cyc(14);
    chk(pll_run, 1'b1);
    chk(oe, 3'b111);
    chk(lock_n, 1'b0);
  endtask

  // one slow test clock pulse, long enough to pass the pin synchroniser
  task automatic tck_pulse;
    tck <= 1'b1;
    cyc(4);
    tck <= 1'b0;
    cyc(4);
  endtask

  task automatic t_test_port;
    trst_n <= 1'b0;
    cyc(6);
    chk(tdo_oe, 1'b0);
    trst_n <= 1'b1;
    tms <= 1'b0;
    cyc(4);
    tck_pulse();
    chk(tdo_oe, 1'b1);
    chk(tdo, 1'b1);
    tdi <= 1'b0;
    tck_pulse();
    chk(tdo, 1'b0);
    tms <= 1'b1;
    tdi <= 1'b1;
    repeat (5) tck_pulse();
    chk(tdo_oe, 1'b0);
  endtask

  initial begin
    cyc(5);
    rst_i <= 1'b0;
    t_reset();
    t_irq_lock();
    t_word(1'b1, 10'h2a5);
    t_word(1'b0, 10'h15a);
    t_out_en();
    t_sleep();
    t_test_port();
    conclude();
  end
endmodule
